//--- pkg/flws_consts.svh
// Offsets, field positions, reset values and timing counts of the supervisor.
// Assumes inclusion by bare name from design and sim files.
`ifndef FLWS_CONSTS_SVH
`define FLWS_CONSTS_SVH

`define FLWS_CLK_KHZ          50000
`define FLWS_WDT_TIMEOUT_MS   900
`define FLWS_WDT_TIMEOUT_CYC  (`FLWS_WDT_TIMEOUT_MS * `FLWS_CLK_KHZ)
`define FLWS_RST_PULSE_US     10
`define FLWS_RST_PULSE_CYC    ((`FLWS_RST_PULSE_US * `FLWS_CLK_KHZ + 999) / 1000)
`define FLWS_CLR_PULSE_US     1
`define FLWS_CLR_PULSE_CYC    ((`FLWS_CLR_PULSE_US * `FLWS_CLK_KHZ + 999) / 1000)

`define FLWS_GATE_NUM         7
`define FLWS_GATE_BRAKE       6

`define FLWS_REG_CTRL         8'h00
`define FLWS_REG_CMD          8'h04
`define FLWS_REG_GATE         8'h08
`define FLWS_REG_STATUS       8'h0C
`define FLWS_REG_IRQ_STAT     8'h10
`define FLWS_REG_IRQ_MASK     8'h14

`define FLWS_CTRL_KICK_DRIVE  0
`define FLWS_CTRL_TX_EN       1
`define FLWS_CTRL_HOM_A_DRV   2
`define FLWS_CTRL_HOM_B_DRV   3
`define FLWS_CTRL_HOM_A_VAL   4
`define FLWS_CTRL_HOM_B_VAL   5
`define FLWS_CTRL_RESET       6'h00

`define FLWS_CMD_KICK         0
`define FLWS_CMD_LATCH_CLR    1
`define FLWS_CMD_GD_CLR       2

`define FLWS_ST_GEN_FAULT     0
`define FLWS_ST_BRK_FAULT     1
`define FLWS_ST_IN_RESET      2
`define FLWS_ST_CLR_BUSY      3
`define FLWS_ST_KICK_LVL      4

`define FLWS_IRQ_GEN_FAULT    0
`define FLWS_IRQ_BRK_FAULT    1
`define FLWS_IRQ_WDT_RESET    2

`endif

//--- pkg/flws_pkg.sv
// Types shared by both ends of the supervisor link.
// Assumes nothing beyond the constants header.
`default_nettype none
package flws_pkg;
  typedef enum logic [1:0] {
    WD_OFF   = 2'h0,
    WD_ARMED = 2'h1,
    WD_RESET = 2'h2
  } flws_wd_state_t;
  typedef logic [6:0] flws_gate_t;
endpackage : flws_pkg
`default_nettype wire

//--- pkg/flws_link_if.sv
// Board-level wires between processor and supervisor logic.
// Assumes both ends run on one clock; undriven homing line reads high.
`default_nettype none
interface flws_link_if;
  logic       watchdog_kick;
  logic       watchdog_kick_oe;
  logic       processor_reset_n;
  logic       general_fault_n;
  logic       brake_fault_n;
  logic       latch_clear_n;
  logic       gate_driver_fault_clear;
  logic [6:0] gate_cmd;
  logic       serial_tx_driver_enable;
  logic       homing_a;
  logic       homing_a_oe;
  logic       homing_b;
  logic       homing_b_oe;
  logic       homing_line;

  // Pull-up when neither pin drives
  assign homing_line = homing_a_oe ? homing_a : (homing_b_oe ? homing_b : 1'b1);

  modport dev (
    input  watchdog_kick, watchdog_kick_oe, latch_clear_n, gate_driver_fault_clear,
    input  gate_cmd, serial_tx_driver_enable, homing_line,
    output processor_reset_n, general_fault_n, brake_fault_n
  );
  modport proc (
    output watchdog_kick, watchdog_kick_oe, latch_clear_n, gate_driver_fault_clear,
    output gate_cmd, serial_tx_driver_enable, homing_a, homing_a_oe, homing_b, homing_b_oe,
    input  processor_reset_n, general_fault_n, brake_fault_n, homing_line
  );
endinterface : flws_link_if
`default_nettype wire

//--- verilog/flws_sync.sv
// Two-stage synchroniser for a vector of slow levels.
// Assumes each bit is an independent level; no bus coherence.
`default_nettype none
module flws_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= d_i;
      q_r    <= meta_r;
    end
  end

  assign q_o = q_r;
endmodule : flws_sync
`default_nettype wire

//--- verilog/flws_supervisor_dev.sv
// Supervisor end: fault latch, gate driver faults, brake fault and watchdog.
// Assumes power-stage short and over-voltage inputs are asynchronous levels.
// Notes on behaviour
// [R1] Undriven kick line keeps watchdog off
// [R2] Processor toggles kick line once driven
// [R3] Missing kick asserts processor reset
// [R4] Timeout at least 0.9 seconds
// [R5] Shorts or over-voltage assert general fault
// [R6] General fault latched until cleared
// [R7] Active-low clear pulse resets fault latch
// [R8] Separate clear resets gate driver faults
// [R9] Brake short asserts brake fault line
// [R10] Processor enables serial driver before sending
// [R11] Six phase gate inputs plus brake
// [R12] Homing pins never both drive
// [R13] Active source keeps latch set during clear
// [R14] Kick edge restarts counter, undriven clears
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`default_nettype none
`include "flws_consts.svh"
module flws_supervisor_dev
  import flws_pkg::*;
#(
  parameter int unsigned WDT_TIMEOUT_CYC = `FLWS_WDT_TIMEOUT_CYC
) (
  input  wire logic             CORE_CLK_I,
  input  wire logic             RST_N_I,
  flws_link_if.dev              LINK,
  input  wire logic [5:0]       PHASE_SHORT_I,
  input  wire logic             BRAKE_SHORT_I,
  input  wire logic             DC_OVERVOLT_I,
  output logic      [6:0]       GATE_DRIVE_O,
  output logic                  SERIAL_TX_DRIVER_ENABLE_O,
  output logic                  HOMING_LEVEL_O,
  output logic      [2:0]       FAULT_CAUSE_O,
  output logic                  WDT_ACTIVE_O,
  output logic      [7:0]       WDT_RESET_COUNT_O
);
  localparam int CNT_W = 26;
  localparam int PLS_W = 10;

  logic [7:0]       raw_src;
  logic [7:0]       src_s;
  logic [5:0]       phase_s;
  logic             brake_s;
  logic             ov_s;
  logic             fault_src;
  flws_gate_t       short_s;

  logic             kick_prev_r;
  logic             kick_oe_prev_r;
  logic             kick_edge;

  flws_wd_state_t   state_r;
  flws_wd_state_t   state_nxt;
  logic [CNT_W-1:0] wd_cnt_r;
  logic [CNT_W-1:0] wd_cnt_nxt;
  logic [PLS_W-1:0] pulse_cnt_r;
  logic [PLS_W-1:0] pulse_cnt_nxt;

  logic             latched_fault_r;
  logic [2:0]       cause_r;
  flws_gate_t       gd_fault_r;
  flws_gate_t       gd_fault_nxt;
  flws_gate_t       gate_r;
  logic             tx_en_r;
  logic             homing_r;
  logic [7:0]       reset_cnt_r;

  // Shorts arrive from comparators off the clock domain
  assign raw_src = {DC_OVERVOLT_I, BRAKE_SHORT_I, PHASE_SHORT_I};

  flws_sync #(
    .W (8)
  ) flws_sync_inst (
    .clk_i   (CORE_CLK_I),
    .rst_n_i (RST_N_I),
    .d_i     (raw_src),
    .q_o     (src_s)
  );

  assign phase_s   = src_s[5:0];
  assign brake_s   = src_s[6];
  assign ov_s      = src_s[7];
  assign short_s   = {brake_s, phase_s};
  assign fault_src = (|phase_s) | brake_s | ov_s; // [R5]

  // Kick history for edge detection
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      kick_prev_r    <= 1'b0;
      kick_oe_prev_r <= 1'b0;
    end else begin
      kick_prev_r    <= LINK.watchdog_kick;
      kick_oe_prev_r <= LINK.watchdog_kick_oe;
    end
  end

  // Edge only counts while driven on both samples; enabling is not a kick
  assign kick_edge = LINK.watchdog_kick_oe & kick_oe_prev_r & (LINK.watchdog_kick != kick_prev_r); // [R14]

  always_comb begin
    state_nxt     = state_r;
    wd_cnt_nxt    = wd_cnt_r;
    pulse_cnt_nxt = pulse_cnt_r;
    case (state_r)
      WD_OFF: begin
        wd_cnt_nxt    = '0; // [R14]
        pulse_cnt_nxt = '0;
        if (LINK.watchdog_kick_oe) begin
          state_nxt = WD_ARMED;
        end
      end
      WD_ARMED: begin
        if (!LINK.watchdog_kick_oe) begin
          state_nxt  = WD_OFF; // [R1]
          wd_cnt_nxt = '0;
        end else if (kick_edge) begin
          wd_cnt_nxt = '0; // [R14]
        end else if (wd_cnt_r == CNT_W'(WDT_TIMEOUT_CYC - 1)) begin
          state_nxt     = WD_RESET; // [R3] [R4]
          wd_cnt_nxt    = '0;
          pulse_cnt_nxt = '0;
        end else begin
          wd_cnt_nxt = wd_cnt_r + 1'b1;
        end
      end
      WD_RESET: begin
        if (!LINK.watchdog_kick_oe) begin
          state_nxt = WD_OFF; // [R1]
        end else if (pulse_cnt_r == PLS_W'(`FLWS_RST_PULSE_CYC - 1)) begin
          state_nxt  = WD_ARMED;
          wd_cnt_nxt = '0;
        end else begin
          pulse_cnt_nxt = pulse_cnt_r + 1'b1;
        end
      end
      default: begin
        state_nxt     = WD_OFF;
        wd_cnt_nxt    = '0;
        pulse_cnt_nxt = '0;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      state_r     <= WD_OFF;
      wd_cnt_r    <= '0;
      pulse_cnt_r <= '0;
    end else begin
      state_r     <= state_nxt;
      wd_cnt_r    <= wd_cnt_nxt;
      pulse_cnt_r <= pulse_cnt_nxt;
    end
  end

  // Saturates so a runaway reset loop stays visible
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      reset_cnt_r <= 8'h00;
    end else if (state_r == WD_ARMED && state_nxt == WD_RESET && reset_cnt_r != 8'hFF) begin
      reset_cnt_r <= reset_cnt_r + 8'h01;
    end
  end

  // Set wins over clear: a live source survives the clear pulse
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      latched_fault_r <= 1'b0;
    end else if (fault_src) begin
      latched_fault_r <= 1'b1; // [R5] [R13]
    end else if (!LINK.latch_clear_n) begin
      latched_fault_r <= 1'b0; // [R7]
    end
  end

  // Cause bits: phase, brake, over-voltage; cleared with the latch
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      cause_r <= 3'h0;
    end else if (fault_src) begin
      cause_r <= cause_r | {ov_s, brake_s, |phase_s}; // [R6]
    end else if (!LINK.latch_clear_n) begin
      cause_r <= 3'h0;
    end
  end

  // One fault flag and gated output per switch
  for (genvar g = 0; g < `FLWS_GATE_NUM; g++) begin : g_gate
    assign gd_fault_nxt[g] = short_s[g] | (gd_fault_r[g] & ~LINK.gate_driver_fault_clear); // [R8]

    always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
        gd_fault_r[g] <= 1'b0;
        gate_r[g]     <= 1'b0;
      end else begin
        gd_fault_r[g] <= gd_fault_nxt[g];
        // Gates off while processor is held in reset
        gate_r[g]     <= LINK.gate_cmd[g] & ~gd_fault_nxt[g] & (state_r != WD_RESET); // [R11]
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      tx_en_r  <= 1'b0;
      homing_r <= 1'b1;
    end else begin
      tx_en_r  <= LINK.serial_tx_driver_enable;
      homing_r <= LINK.homing_line;
    end
  end

  assign LINK.processor_reset_n = (state_r != WD_RESET); // [R3]
  assign LINK.general_fault_n   = ~latched_fault_r; // [R6]
  assign LINK.brake_fault_n     = ~gd_fault_r[`FLWS_GATE_BRAKE]; // [R9]

  assign GATE_DRIVE_O              = gate_r;
  assign SERIAL_TX_DRIVER_ENABLE_O = tx_en_r;
  assign HOMING_LEVEL_O            = homing_r;
  assign FAULT_CAUSE_O             = cause_r;
  assign WDT_ACTIVE_O              = (state_r != WD_OFF);
  assign WDT_RESET_COUNT_O         = reset_cnt_r;
endmodule : flws_supervisor_dev
`default_nettype wire

//--- verilog/flws_proc_host.sv
// Processor end: drives kick, clears, gates and pins from AHB-Lite registers.
// Assumes one clock shared with the supervisor; zero-wait slave.
`default_nettype none
`include "flws_consts.svh"
module flws_proc_host
  import flws_pkg::*;
(
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  output logic      [31:0] HRDATA_O,
  output logic             IRQ_O,
  flws_link_if.proc        LINK
);
  logic [5:0]  ctrl_r;
  flws_gate_t  gate_r;
  logic        kick_lvl_r;
  logic [2:0]  irq_stat_r;
  logic [2:0]  irq_mask_r;
  logic [2:0]  irq_ev;
  logic        gen_prev_r;
  logic        brk_prev_r;
  logic        rst_prev_r;
  logic        wr_en_r;
  logic [7:0]  addr_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_val;
  logic [5:0]  wsel;
  logic [5:0]  rsel;
  logic        acc;
  logic [1:0]  clr_req;
  logic [1:0]  clr_act;
  logic [5:0]  clr_cnt_r [2];
  logic        in_reset;

  // One-hot register select; all zero when unmapped or misaligned
  function automatic logic [5:0] reg_sel(input logic [7:0] a);
    logic [5:0] s;
    s = 6'h00;
    case (a)
      `FLWS_REG_CTRL:     s = 6'h01;
      `FLWS_REG_CMD:      s = 6'h02;
      `FLWS_REG_GATE:     s = 6'h04;
      `FLWS_REG_STATUS:   s = 6'h08;
      `FLWS_REG_IRQ_STAT: s = 6'h10;
      `FLWS_REG_IRQ_MASK: s = 6'h20;
      default:            s = 6'h00;
    endcase
    return s;
  endfunction : reg_sel

  assign acc      = HSEL_I & HTRANS_I[1] & HREADY_I;
  assign in_reset = ~LINK.processor_reset_n;

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      wr_en_r <= 1'b0;
      addr_r  <= 8'h00;
    end else begin
      wr_en_r <= acc & HWRITE_I & (HSIZE_I == 3'h2) & (HADDR_I[31:8] == 24'h000000);
      addr_r  <= HADDR_I[7:0];
    end
  end

  assign wsel = wr_en_r ? reg_sel(addr_r) : 6'h00;
  assign rsel = (HADDR_I[31:8] == 24'h000000) ? reg_sel(HADDR_I[7:0]) : 6'h00;

  // Watchdog reset also resets this processor's pin state
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I || in_reset) begin
      ctrl_r     <= `FLWS_CTRL_RESET;
      gate_r     <= '0;
      kick_lvl_r <= 1'b0;
    end else begin
      if (wsel[0]) begin
        ctrl_r <= HWDATA_I[5:0];
      end
      if (wsel[2]) begin
        gate_r <= HWDATA_I[6:0];
      end
      if (wsel[1] && HWDATA_I[`FLWS_CMD_KICK]) begin
        kick_lvl_r <= ~kick_lvl_r; // [R2]
      end
    end
  end

  assign clr_req = wsel[1] ? {HWDATA_I[`FLWS_CMD_GD_CLR], HWDATA_I[`FLWS_CMD_LATCH_CLR]} : 2'h0;

  // Both clears fire once at boot, then on command
  for (genvar i = 0; i < 2; i++) begin : g_clr
    always_ff @(posedge CORE_CLK_I) begin
      if (!RST_N_I) begin
        clr_cnt_r[i] <= 6'(`FLWS_CLR_PULSE_CYC); // [R7] [R8]
      end else if (clr_req[i]) begin
        clr_cnt_r[i] <= 6'(`FLWS_CLR_PULSE_CYC);
      end else if (clr_cnt_r[i] != 6'h00) begin
        clr_cnt_r[i] <= clr_cnt_r[i] - 6'h01;
      end
    end
    assign clr_act[i] = (clr_cnt_r[i] != 6'h00);
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      gen_prev_r <= 1'b1;
      brk_prev_r <= 1'b1;
      rst_prev_r <= 1'b1;
    end else begin
      gen_prev_r <= LINK.general_fault_n;
      brk_prev_r <= LINK.brake_fault_n;
      rst_prev_r <= LINK.processor_reset_n;
    end
  end

  assign irq_ev = {rst_prev_r & ~LINK.processor_reset_n,
                   brk_prev_r & ~LINK.brake_fault_n,
                   gen_prev_r & ~LINK.general_fault_n};

  // New event wins over a write-one clear in the same cycle
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      irq_stat_r <= 3'h0;
      irq_mask_r <= 3'h0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~(wsel[4] ? HWDATA_I[2:0] : 3'h0)) | irq_ev;
      if (wsel[5]) begin
        irq_mask_r <= HWDATA_I[2:0];
      end
    end
  end

  always_comb begin
    rd_val = 32'h00000000;
    if (rsel[0]) begin
      rd_val[5:0] = ctrl_r;
    end
    if (rsel[2]) begin
      rd_val[6:0] = gate_r;
    end
    if (rsel[3]) begin
      rd_val[`FLWS_ST_GEN_FAULT] = ~LINK.general_fault_n;
      rd_val[`FLWS_ST_BRK_FAULT] = ~LINK.brake_fault_n;
      rd_val[`FLWS_ST_IN_RESET]  = in_reset;
      rd_val[`FLWS_ST_CLR_BUSY]  = |clr_act;
      rd_val[`FLWS_ST_KICK_LVL]  = kick_lvl_r;
    end
    if (rsel[4]) begin
      rd_val[2:0] = irq_stat_r;
    end
    if (rsel[5]) begin
      rd_val[2:0] = irq_mask_r;
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      hrdata_r <= 32'h00000000;
    end else if (acc && !HWRITE_I) begin
      hrdata_r <= rd_val;
    end
  end

  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;
  assign HRDATA_O    = hrdata_r;
  assign IRQ_O       = |(irq_stat_r & irq_mask_r);

  assign LINK.watchdog_kick           = kick_lvl_r;
  assign LINK.watchdog_kick_oe        = ctrl_r[`FLWS_CTRL_KICK_DRIVE]; // [R1] [R2]
  assign LINK.latch_clear_n           = ~clr_act[0]; // [R7]
  assign LINK.gate_driver_fault_clear = clr_act[1]; // [R8]
  assign LINK.gate_cmd                = gate_r;
  assign LINK.serial_tx_driver_enable = ctrl_r[`FLWS_CTRL_TX_EN]; // [R10]
  assign LINK.homing_a                = ctrl_r[`FLWS_CTRL_HOM_A_VAL];
  assign LINK.homing_a_oe             = ctrl_r[`FLWS_CTRL_HOM_A_DRV];
  assign LINK.homing_b                = ctrl_r[`FLWS_CTRL_HOM_B_VAL];
  // Pin A takes priority so both never drive together
  assign LINK.homing_b_oe             = ctrl_r[`FLWS_CTRL_HOM_B_DRV] & ~ctrl_r[`FLWS_CTRL_HOM_A_DRV]; // [R12]
endmodule : flws_proc_host
`default_nettype wire

//--- sim/flws_link_sva.sv
// Assertions on the processor to supervisor link wires.
// Assumes instantiation beside the link interface, one clock.
`default_nettype none
`include "flws_consts.svh"
module flws_link_sva #(
  parameter int unsigned WDT_TIMEOUT_CYC = `FLWS_WDT_TIMEOUT_CYC
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  input wire logic watchdog_kick,
  input wire logic watchdog_kick_oe,
  input wire logic processor_reset_n,
  input wire logic general_fault_n,
  input wire logic brake_fault_n,
  input wire logic latch_clear_n,
  input wire logic gate_driver_fault_clear
);
  logic [31:0] idle_r;
  logic        kick_q_r;
  logic        oe_q_r;

  always_ff @(posedge CORE_CLK_I) begin
    kick_q_r <= watchdog_kick;
    oe_q_r   <= watchdog_kick_oe;
  end

  // Cycles since last kick edge or enable; saturates so it never wraps to zero
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I || !watchdog_kick_oe || !oe_q_r || watchdog_kick != kick_q_r) begin
      idle_r <= 32'h0;
    end else if (idle_r != 32'hFFFFFFFF) begin
      idle_r <= idle_r + 32'h1;
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_undriven_no_reset: assert property (!watchdog_kick_oe [*3] |-> processor_reset_n)
    else $error("reset with kick undriven");
  a_reset_on_time: assert property ($fell(processor_reset_n) |-> idle_r == WDT_TIMEOUT_CYC)
    else $error("reset at wrong count");
  a_no_early_reset: assert property (watchdog_kick_oe && idle_r < WDT_TIMEOUT_CYC |-> processor_reset_n)
    else $error("reset before timeout");
  a_fault_latch_held: assert property (!general_fault_n && latch_clear_n |=> !general_fault_n)
    else $error("fault left latch");
  a_brake_flag_held: assert property (!brake_fault_n && !gate_driver_fault_clear |=> !brake_fault_n)
    else $error("brake flag left");
  a_brake_sets_fault: assert property ($fell(brake_fault_n) |-> !general_fault_n)
    else $error("brake without fault");
  a_boot_clears: assert property ($rose(RST_N_I) |-> (!latch_clear_n && gate_driver_fault_clear) [*8])
    else $error("no boot clear");
  a_clear_pulse_len: assert property ($fell(latch_clear_n) |-> !latch_clear_n [*8])
    else $error("latch clear short");
  a_gd_pulse_len: assert property ($rose(gate_driver_fault_clear) |-> gate_driver_fault_clear [*8])
    else $error("gd clear short");
endmodule : flws_link_sva
`default_nettype wire

//--- sim/fault_latch_and_watchdog_supervisor_tb.sv
// Bench: host and supervisor joined by the link, AHB master on host.
// Assumes a shortened watchdog count; constants header on include path.
`default_nettype none
`include "flws_consts.svh"
module fault_latch_and_watchdog_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TO = 200;
  logic        core_clk = 1'b0;
  logic        rst_n    = 1'b0;
  logic [1:0]  htrans   = 2'h0;
  logic [31:0] haddr    = 32'h0;
  logic [31:0] hwdata   = 32'h0;
  logic        hwrite   = 1'b0;
  logic [5:0]  ph_sc    = 6'h0;
  logic        brk_sc   = 1'b0;
  logic        ov       = 1'b0;
  logic        hready;
  logic        hresp;
  logic        irq;
  logic        tx_en;
  logic        homing;
  logic [31:0] hrdata;
  logic [6:0]  gates;
  logic [2:0]  cause;
  logic        wdt_act;
  logic [7:0]  wdt_cnt;
  int          n_mismatch = 0;
  int          checked    = 0;

  always #10 core_clk = ~core_clk;

  flws_link_if link ();
  flws_supervisor_dev #(.WDT_TIMEOUT_CYC(TO)) flws_supervisor_dev_inst (
    .CORE_CLK_I(core_clk), .RST_N_I(rst_n), .LINK(link), .PHASE_SHORT_I(ph_sc),
    .BRAKE_SHORT_I(brk_sc), .DC_OVERVOLT_I(ov), .GATE_DRIVE_O(gates), .SERIAL_TX_DRIVER_ENABLE_O(tx_en),
    .HOMING_LEVEL_O(homing), .FAULT_CAUSE_O(cause), .WDT_ACTIVE_O(wdt_act), .WDT_RESET_COUNT_O(wdt_cnt));
  flws_proc_host flws_proc_host_inst (
    .CORE_CLK_I(core_clk), .RST_N_I(rst_n), .HSEL_I(1'b1), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready), .HREADYOUT_O(hready),
    .HRESP_O(hresp), .HRDATA_O(hrdata), .IRQ_O(irq), .LINK(link));
  flws_link_sva #(.WDT_TIMEOUT_CYC(TO)) flws_link_sva_inst (
    .CORE_CLK_I(core_clk), .RST_N_I(rst_n), .watchdog_kick(link.watchdog_kick),
    .watchdog_kick_oe(link.watchdog_kick_oe), .processor_reset_n(link.processor_reset_n),
    .general_fault_n(link.general_fault_n), .brake_fault_n(link.brake_fault_n),
    .latch_clear_n(link.latch_clear_n), .gate_driver_fault_clear(link.gate_driver_fault_clear));

  task automatic conclude();
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // One single word transfer; waits on hready, no fixed latency assumed
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    haddr  <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, hresp);
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    ahb(1'b1, a, d, rd);
  endtask : wr

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    ahb(1'b0, a, 32'h0, rd);
    chk(nm, exp, rd);
  endtask : rdchk

  task automatic t_boot();
    chk("boot latch clear", 32'h0, link.latch_clear_n);
    chk("boot gd clear", 32'h1, link.gate_driver_fault_clear);
    tick(60);
    chk("fault idle", 32'h1, link.general_fault_n);
    rdchk("unmapped", 8'h40, 32'h0);
    rdchk("cmd", `FLWS_REG_CMD, 32'h0);
    wr(`FLWS_REG_GATE, 32'h2A);
    tick(3);
    chk("gates", 32'h2A, gates);
    wr(`FLWS_REG_GATE, 32'h7F);
    tick(3);
    chk("gates", 32'h7F, gates);
    rdchk("gate reg", `FLWS_REG_GATE, 32'h7F);
  endtask : t_boot

  task automatic t_pins();
    logic [7:0] ctl [4] = '{8'h00, 8'h04, 8'h08, 8'h2E};
    logic       hom [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
    for (int i = 0; i < 4; i++) begin
      wr(`FLWS_REG_CTRL, {24'h0, ctl[i]});
      tick(3);
      chk("homing", hom[i], homing);
      chk("tx enable", ctl[i][1], tx_en);
    end
  endtask : t_pins

  // Each source in turn; gd clear first so the latch is seen to hold
  task automatic t_faults();
    logic brk;
    wr(`FLWS_REG_IRQ_MASK, 32'h2);
    for (int i = 0; i < 8; i++) begin
      brk = (i == 6);
      ph_sc  <= (i < 6) ? 6'h1 << i : 6'h0;
      brk_sc <= brk;
      ov     <= (i == 7);
      tick(6);
      ph_sc  <= 6'h0;
      brk_sc <= 1'b0;
      ov     <= 1'b0;
      tick(6);
      chk("fault latched", 32'h0, link.general_fault_n);
      chk("brake flag", !brk, link.brake_fault_n);
      if (brk) chk("brake gate", 32'h0, gates[6]);
      chk("cause", (i < 6) ? 3'h1 : (brk ? 3'h2 : 3'h4), cause);
      chk("irq masked", brk, irq);
      rdchk("irq stat", `FLWS_REG_IRQ_STAT, brk ? 32'h3 : 32'h1);
      rdchk("status", `FLWS_REG_STATUS, brk ? 32'h3 : 32'h1);
      wr(`FLWS_REG_IRQ_STAT, 32'h7);
      wr(`FLWS_REG_CMD, 32'h4);
      tick(60);
      chk("brake cleared", 32'h1, link.brake_fault_n);
      chk("fault kept", 32'h0, link.general_fault_n);
      wr(`FLWS_REG_CMD, 32'h2);
      tick(60);
      chk("fault cleared", 32'h1, link.general_fault_n);
      chk("irq low", 32'h0, irq);
      chk("gates back", 32'h7F, gates);
    end
  endtask : t_faults

  task automatic t_hold();
    ov <= 1'b1;
    tick(6);
    wr(`FLWS_REG_CMD, 32'h2);
    tick(60);
    chk("fault in clear", 32'h0, link.general_fault_n);
    ov <= 1'b0;
    tick(6);
    wr(`FLWS_REG_CMD, 32'h2);
    tick(60);
    chk("fault cleared", 32'h1, link.general_fault_n);
    wr(`FLWS_REG_IRQ_STAT, 32'h7);
  endtask : t_hold

  task automatic t_wdt();
    int n;
    wr(`FLWS_REG_CTRL, 32'h0);
    wr(`FLWS_REG_CMD, 32'h1);
    tick(3 * TO);
    chk("reset undriven", 32'h1, link.processor_reset_n);
    chk("wdt off", 32'h0, wdt_act);
    wr(`FLWS_REG_CTRL, 32'h1);
    tick(2);
    chk("wdt armed", 32'h1, wdt_act);
    for (int i = 0; i < 6; i++) begin
      wr(`FLWS_REG_CMD, 32'h1);
      tick(TO - 20);
    end
    chk("reset kicked", 32'h1, link.processor_reset_n);
    wr(`FLWS_REG_CMD, 32'h1);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (link.processor_reset_n !== 1'b0 && n < 2 * TO);
    chk("timeout cycles", TO + 2, n);
    tick(20);
    chk("reset released", 32'h1, link.processor_reset_n);
    chk("timeouts", 32'h1, wdt_cnt);
    rdchk("ctrl cleared", `FLWS_REG_CTRL, 32'h0);
    rdchk("irq stat", `FLWS_REG_IRQ_STAT, 32'h4);
    wr(`FLWS_REG_IRQ_MASK, 32'h4);
    tick(2);
    chk("irq raised", 32'h1, irq);
    wr(`FLWS_REG_IRQ_STAT, 32'h4);
    tick(2);
    chk("irq cleared", 32'h0, irq);
    // Enabling alone starts the count from zero
    wr(`FLWS_REG_CTRL, 32'h1);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (link.processor_reset_n !== 1'b0 && n < 2 * TO);
    chk("enable timeout", TO + 2, n);
    tick(20);
    chk("timeouts", 32'h2, wdt_cnt);
  endtask : t_wdt

  initial begin
    tick(10);
    rst_n <= 1'b1;
    tick(1);
    t_boot();
    t_pins();
    t_faults();
    t_hold();
    t_wdt();
    conclude();
  end

  // Whole run is near 3500 cycles; limit well above
  initial begin
    tick(20000);
    n_mismatch++;
    conclude();
  end
endmodule : fault_latch_and_watchdog_supervisor_tb
`default_nettype wire
